// ---- design/dma_list_base_hash_irq_regs.sv ----
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
// list base, multicast hash and interrupt enable registers on avalon-mm
module dma_list_base_hash_irq_regs (
  input  wire logic                               mclk_i,
  input  wire logic                               sys_rst_i,
  // avalon-mm slave
  input  wire logic [7:0]                         avs_address_i,
  input  wire logic                               avs_read_i,
  input  wire logic                               avs_write_i,
  input  wire logic [31:0]                        avs_writedata_i,
  input  wire logic [3:0]                         avs_byteenable_i,
  output logic [31:0]                             avs_readdata_o,
  output logic                                    avs_waitrequest_o,
  // process state from the dma engine
  input  wire logic                               tx_running_i,
  input  wire logic                               rx_running_i,
  // one-cycle event pulses, bit order as the status word from bit 25 up
  input  wire logic [dma_regs_pkg::NUM_EVENTS-1:0] event_pulse_i,
  // hash lookup from the receive path
  input  wire logic                               hash_valid_i,
  input  wire logic [dma_regs_pkg::HASH_BITS-1:0] hash_index_i,
  output logic                                    mcast_accept_valid_o,
  output logic                                    mcast_accept_o,
  // register contents towards the dma engine
  output logic [31:0]                             tx_descriptor_list_base_o,
  output logic [31:0]                             rx_descriptor_list_base_o,
  output logic                                    irq_o
);
  import dma_regs_pkg::*;

  typedef struct packed {
    logic [31:0]           tx_base;
    logic [31:0]           rx_base;
    logic [31:0]           hash_low;
    logic [31:0]           hash_high;
    logic [NUM_EVENTS-1:0] irq_en;
    logic [NUM_EVENTS-1:0] irq_stat;
    logic [2:0]            filter_ctl;
    logic [31:0]           rdata;
    logic                  ack;
    logic                  irq;
  } reg_state_t;

  reg_state_t s_q;
  reg_state_t s_d;

  logic            access;
  logic            wr_hit;
  logic [31:0]     wmask;
  logic [31:0]     wdata_m;
  logic [31:0]     rd_word;
  logic [NUM_EVENTS-1:0] clr_bits;

  // ==========================================================
  // byte enables widened to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mask
      assign wmask[g*8 +: 8] = {8{avs_byteenable_i[g]}};
    end
  endgenerate

  // ==========================================================
  // register file and bus answer
  // every access waits exactly one cycle: waitrequest drops on the cycle after
  // the request is seen, which keeps read data registered
  always_comb begin
    s_d     = s_q;
    access  = (avs_read_i | avs_write_i) & ~s_q.ack;
    wr_hit  = avs_write_i & access;
    wdata_m = avs_writedata_i & wmask;
    rd_word = UNMAPPED_DATA;
    clr_bits = '0;
    s_d.ack = access;

    // read decode, reserved words and bits read zero
    if (avs_address_i == TX_LIST_BASE_OFS) begin
      rd_word = s_q.tx_base;
    end else if (avs_address_i == RX_LIST_BASE_OFS) begin
      rd_word = s_q.rx_base;
    end else if (avs_address_i == HASH_LOW_OFS) begin
      rd_word = s_q.hash_low;
    end else if (avs_address_i == HASH_HIGH_OFS) begin
      rd_word = s_q.hash_high;
    end else if (avs_address_i == IRQ_EN_OFS) begin
      rd_word = {s_q.irq_en, 25'h0000000};
    end else if (avs_address_i == IRQ_STATUS_OFS) begin
      rd_word = {s_q.irq_stat, 25'h0000000}; // reading does not clear
    end else if (avs_address_i == RX_FILTER_CTL_OFS) begin
      rd_word = {29'h00000000, s_q.filter_ctl};
    end else begin
      rd_word = UNMAPPED_DATA; // reserved 0x18, 0x1c and unmapped
    end
    s_d.rdata = (avs_read_i & access) ? rd_word : s_q.rdata;

    // write decode
    if (wr_hit) begin
      if (avs_address_i == TX_LIST_BASE_OFS) begin
        if (!tx_running_i) begin
          s_d.tx_base = (s_q.tx_base & ~wmask) | wdata_m;
        end
      end else if (avs_address_i == RX_LIST_BASE_OFS) begin
        if (!rx_running_i) begin
          s_d.rx_base = (s_q.rx_base & ~wmask) | wdata_m;
        end
      end else if (avs_address_i == HASH_LOW_OFS) begin
        s_d.hash_low = (s_q.hash_low & ~wmask) | wdata_m;
      end else if (avs_address_i == HASH_HIGH_OFS) begin
        s_d.hash_high = (s_q.hash_high & ~wmask) | wdata_m;
      end else if (avs_address_i == IRQ_EN_OFS) begin
        // bits 31..25 all sit in byte lane 3
        if (avs_byteenable_i[3]) begin
          s_d.irq_en = avs_writedata_i[31:IRQ_LSB];
        end
      end else if (avs_address_i == IRQ_STATUS_OFS) begin
        clr_bits = avs_writedata_i[31:IRQ_LSB] & {NUM_EVENTS{avs_byteenable_i[3]}};
      end else if (avs_address_i == RX_FILTER_CTL_OFS) begin
        if (avs_byteenable_i[0]) begin
          s_d.filter_ctl = avs_writedata_i[2:0];
        end
      end
    end

    // sticky status: an event in the clearing cycle still sets its bit
    s_d.irq_stat = (s_q.irq_stat & ~clr_bits) | event_pulse_i;

    // interrupt line follows any enabled pending event
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q.tx_base    <= LIST_BASE_RST;
      s_q.rx_base    <= LIST_BASE_RST;
      s_q.hash_low   <= HASH_RST;
      s_q.hash_high  <= HASH_RST;
      s_q.irq_en     <= IRQ_RST;
      s_q.irq_stat   <= IRQ_RST;
      s_q.filter_ctl <= FILTER_RST;
      s_q.rdata      <= UNMAPPED_DATA;
      s_q.ack        <= 1'b0;
      s_q.irq        <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // hash filter; the list alignment is the host's duty and is not checked
  mcast_hash_filter u_filter (
    .mclk_i         (mclk_i),
    .sys_rst_i      (sys_rst_i),
    .hash_low_i     (s_q.hash_low),
    .hash_high_i    (s_q.hash_high),
    .filter_ctl_i   (s_q.filter_ctl),
    .hash_valid_i   (hash_valid_i),
    .hash_index_i   (hash_index_i),
    .accept_valid_o (mcast_accept_valid_o),
    .accept_o       (mcast_accept_o)
  );

  // outputs straight from flip-flops, except waitrequest, which is decoded from read/write and ack
  assign avs_readdata_o            = s_q.rdata;
  assign avs_waitrequest_o         = (avs_read_i | avs_write_i) & ~s_q.ack;
  assign tx_descriptor_list_base_o = s_q.tx_base;
  assign rx_descriptor_list_base_o = s_q.rx_base;
  assign irq_o                     = s_q.irq;

endmodule : dma_list_base_hash_irq_regs

// ---- design/mcast_hash_filter.sv ----
`timescale 1ns/1ps
// multicast accept decision, registered one cycle after the hash strobe
module mcast_hash_filter (
  input  wire logic                               mclk_i,
  input  wire logic                               sys_rst_i,
  input  wire logic [31:0]                        hash_low_i,
  input  wire logic [31:0]                        hash_high_i,
  input  wire logic [2:0]                         filter_ctl_i,
  input  wire logic                               hash_valid_i,
  input  wire logic [dma_regs_pkg::HASH_BITS-1:0] hash_index_i,
  output logic                                    accept_valid_o,
  output logic                                    accept_o
);
  import dma_regs_pkg::*;

  typedef struct packed {
    logic valid;
    logic accept;
  } flt_state_t;

  flt_state_t s_q;
  flt_state_t s_d;
  logic       table_bit;

  // ==========================================================
  // decision
  always_comb begin
    // top index bit picks the word, low five the bit
    table_bit = hash_index_i[HASH_BITS-1] ? hash_high_i[hash_index_i[4:0]]
                                          : hash_low_i[hash_index_i[4:0]];
    s_d        = s_q;
    s_d.valid  = hash_valid_i;
    s_d.accept = filter_ctl_i[FLT_ALL_FRAMES] | filter_ctl_i[FLT_ALL_MCAST]
               | (filter_ctl_i[FLT_HASH_EN] & table_bit);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign accept_valid_o = s_q.valid;
  assign accept_o       = s_q.accept;

endmodule : mcast_hash_filter

// ---- shared/dma_regs_pkg.sv ----
package dma_regs_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] TX_LIST_BASE_OFS = 8'h10;
  localparam logic [7:0] RX_LIST_BASE_OFS = 8'h14;
  localparam logic [7:0] RSVD_A_OFS       = 8'h18;
  localparam logic [7:0] RSVD_B_OFS       = 8'h1c;
  localparam logic [7:0] HASH_LOW_OFS     = 8'h20;
  localparam logic [7:0] HASH_HIGH_OFS    = 8'h24;
  localparam logic [7:0] IRQ_EN_OFS       = 8'h28;
  localparam logic [7:0] IRQ_STATUS_OFS   = 8'h2c;
  // added word: receive filter control bits
  localparam logic [7:0] RX_FILTER_CTL_OFS = 8'h30;

  // ==========================================================
  // reset values
  localparam logic [31:0] LIST_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] HASH_RST      = 32'h0000_0000;
  localparam logic [6:0]  IRQ_RST       = 7'h00;
  localparam logic [2:0]  FILTER_RST    = 3'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // ==========================================================
  // field positions
  localparam int IRQ_LSB          = 25; // events occupy bits 31..25
  localparam int NUM_EVENTS       = 7;
  localparam int EV_RX_STOPPED    = 0;  // bit 25
  localparam int EV_TX_STOPPED    = 1;  // bit 26
  localparam int EV_RX_UNAVAIL    = 2;  // bit 27
  localparam int EV_TX_UNAVAIL    = 3;  // bit 28
  localparam int EV_RX_DONE       = 4;  // bit 29
  localparam int EV_TX_DONE       = 5;  // bit 30
  localparam int EV_LINK_CHANGE   = 6;  // bit 31
  localparam int FLT_HASH_EN      = 0;
  localparam int FLT_ALL_FRAMES   = 1;
  localparam int FLT_ALL_MCAST    = 2;
  localparam int HASH_BITS        = 6;

endpackage : dma_regs_pkg

// ---- testbench/dma_regs_checker.sv ----
`timescale 1ns/1ps
// ====
// port-level checks of the register bank
module dma_regs_checker
  import dma_regs_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        tx_running_i,
  input wire logic        rx_running_i,
  input wire logic [6:0]  event_pulse_i,
  input wire logic        hash_valid_i,
  input wire logic        mcast_accept_valid_o,
  input wire logic [31:0] tx_descriptor_list_base_o,
  input wire logic [31:0] rx_descriptor_list_base_o,
  input wire logic        irq_o
);
  logic c1_q, c2_q;
  wire  take = avs_waitrequest_o && avs_write_i;
  wire  tx_hit = take && avs_address_i == TX_LIST_BASE_OFS && !tx_running_i;
  wire  rx_hit = take && avs_address_i == RX_LIST_BASE_OFS && !rx_running_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // irq may only move within two edges after a write or an event
  always_ff @(posedge mclk_i) begin
    c1_q <= avs_write_i || (event_pulse_i != 7'h00);
    c2_q <= c1_q;
  end
  sequence s_rd_taken;
    avs_read_i && avs_waitrequest_o;
  endsequence
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest held too long");
  a_tx_load: assert property (tx_hit && avs_byteenable_i == 4'hf
    |=> tx_descriptor_list_base_o == $past(avs_writedata_i)) else $error("tx base lost");
  a_tx_keep: assert property (!tx_hit |=> $stable(tx_descriptor_list_base_o))
    else $error("tx base moved");
  a_rx_load: assert property (rx_hit && avs_byteenable_i == 4'hf
    |=> rx_descriptor_list_base_o == $past(avs_writedata_i)) else $error("rx base lost");
  a_rx_keep: assert property (!rx_hit |=> $stable(rx_descriptor_list_base_o))
    else $error("rx base moved");
  a_rsvd_zero: assert property (s_rd_taken ##0 avs_address_i[7:3] == 5'h03
    |=> avs_readdata_o == 32'h0) else $error("reserved word not zero");
  a_accept_pulse: assert property (hash_valid_i |=> mcast_accept_valid_o)
    else $error("no accept strobe");
  a_accept_idle: assert property (!hash_valid_i |=> !mcast_accept_valid_o)
    else $error("spurious accept strobe");
  a_irq_cause: assert property ($changed(irq_o) |-> c1_q || c2_q)
    else $error("irq moved without cause");
endmodule : dma_regs_checker

// ---- testbench/host_bus_model.sv ----
`timescale 1ns/1ps
// ====
// host driver: avalon-mm master towards the register bank
module host_bus_model (
  input  wire logic        mclk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        wait_i,
  output logic [7:0]       addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic [31:0]      wdata_o
);
  initial {addr_o, rd_o, wr_o, wdata_o} = '0;
  // one transfer; no fixed latency is assumed, the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= !w;
    do @(posedge mclk_i); while (wait_i !== 1'b0);
    q = rdata_i;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  endtask : xfer
endmodule : host_bus_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
// ====
// register bank bench
module testbench;
  import dma_regs_pkg::*;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic tx_running_i = 1'b0, rx_running_i = 1'b0, hash_valid_i = 1'b0;
  logic mcast_accept_valid_o, mcast_accept_o, irq_o;
  logic [7:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [5:0]  hash_index_i = 6'h00;
  logic [6:0]  event_pulse_i = 7'h00;
  logic [31:0] avs_writedata_i, avs_readdata_o, tx_descriptor_list_base_o;
  logic [31:0] rx_descriptor_list_base_o;
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 mclk_i = ~mclk_i;
  dma_list_base_hash_irq_regs dma_list_base_hash_irq_regs_inst (.mclk_i, .sys_rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .tx_running_i, .rx_running_i, .event_pulse_i,
    .hash_valid_i, .hash_index_i, .mcast_accept_valid_o, .mcast_accept_o,
    .tx_descriptor_list_base_o, .rx_descriptor_list_base_o, .irq_o);
  host_bus_model host_inst (.mclk_i, .rdata_i(avs_readdata_o), .wait_i(avs_waitrequest_o),
    .addr_o(avs_address_i), .rd_o(avs_read_i), .wr_o(avs_write_i), .wdata_o(avs_writedata_i));
  // ====
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_inst.xfer(1'b1, a, d, q);
  endtask : put
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host_inst.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd_chk
  // one hash strobe, decision sampled once its edge has landed
  task automatic look(input logic [5:0] idx, input logic exp);
    hash_valid_i <= 1'b1;
    hash_index_i <= idx;
    @(posedge mclk_i);
    hash_valid_i <= 1'b0;
    #1;
    check({31'h0, mcast_accept_valid_o}, 32'h1);
    check({31'h0, mcast_accept_o}, {31'h0, exp});
  endtask : look
  task automatic pulse(input int k);
    event_pulse_i <= 7'(1 << k);
    @(posedge mclk_i);
    event_pulse_i <= 7'h00;
  endtask : pulse
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk_i);
    #1;
    check({31'h0, irq_o}, {31'h0, e});
  endtask : irq_is
  task automatic end_sim;
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // ====
  // main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int a = 'h10; a <= 'h30; a += 4) rd_chk(8'(a), 32'h0);
    put(TX_LIST_BASE_OFS, 32'h1234_5670);
    tx_running_i <= 1'b1;
    put(TX_LIST_BASE_OFS, 32'hffff_fff0);
    put(RX_LIST_BASE_OFS, 32'h89ab_cde4);
    rd_chk(TX_LIST_BASE_OFS, 32'h1234_5670);
    rd_chk(RX_LIST_BASE_OFS, 32'h89ab_cde4);
    rx_running_i <= 1'b1;
    tx_running_i <= 1'b0;
    put(RX_LIST_BASE_OFS, 32'h0000_0100);
    check(rx_descriptor_list_base_o, 32'h89ab_cde4);
    check(tx_descriptor_list_base_o, 32'h1234_5670);
    put(RSVD_A_OFS, 32'hffff_ffff);
    put(RSVD_B_OFS, 32'hffff_ffff);
    rd_chk(RSVD_B_OFS, 32'h0);
    put(IRQ_EN_OFS, 32'hffff_ffff);
    rd_chk(IRQ_EN_OFS, 32'hfe00_0000);
    put(IRQ_EN_OFS, 32'h0);
    // hash table: bit 2 of the low word, bit 31 of the high word
    put(HASH_LOW_OFS, 32'h0000_0004);
    put(HASH_HIGH_OFS, 32'h8000_0000);
    rd_chk(HASH_HIGH_OFS, 32'h8000_0000);
    put(RX_FILTER_CTL_OFS, 32'h1);
    look(6'd2, 1'b1);
    look(6'd34, 1'b0);
    look(6'd63, 1'b1);
    look(6'd31, 1'b0);
    put(RX_FILTER_CTL_OFS, 32'h0);
    look(6'd2, 1'b0);
    put(RX_FILTER_CTL_OFS, 32'h2);
    look(6'd3, 1'b1);
    put(RX_FILTER_CTL_OFS, 32'h4);
    look(6'd3, 1'b1);
    // every event: masked, enabled, read without clearing, cleared by one
    for (int k = 0; k < NUM_EVENTS; k++) begin
      pulse(k);
      irq_is(1'b0);
      put(IRQ_EN_OFS, 32'h1 << (IRQ_LSB + k));
      irq_is(1'b1);
      rd_chk(IRQ_STATUS_OFS, 32'h1 << (IRQ_LSB + k));
      irq_is(1'b1);
      put(IRQ_STATUS_OFS, 32'h1 << (IRQ_LSB + k));
      irq_is(1'b0);
    end
    end_sim();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule : testbench
bind dma_list_base_hash_irq_regs dma_regs_checker chk_inst (.mclk_i, .sys_rst_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .tx_running_i, .rx_running_i, .event_pulse_i,
  .hash_valid_i, .mcast_accept_valid_o, .tx_descriptor_list_base_o,
  .rx_descriptor_list_base_o, .irq_o);
